/* hw/radio_regs_defs.svh */
`ifndef RADIO_REGS_DEFS_SVH
`define RADIO_REGS_DEFS_SVH
// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define OFS_FLAGS2        7'h3f
`define OFS_MAP_LOW       7'h40
`define OFS_MAP_HIGH      7'h41
`define OFS_REVISION      7'h42
`define OFS_GAIN_REF      7'h43
`define OFS_GAIN_TH1      7'h44
`define OFS_GAIN_TH2      7'h45
`define OFS_GAIN_TH3      7'h46
`define OFS_HOP           7'h4b
`define OFS_REF_SEL       7'h58
`define OFS_BOOST         7'h5a
`define OFS_LOOP_BW       7'h5c
`define OFS_LOW_PN_BW     7'h5e
`define OFS_CAL_TEMP      7'h6c
`define OFS_RATE_FRAC     7'h70
`define OFS_SEQ_CTRL      7'h71
`define OFS_SEQ_TIMERS    7'h72
`define OFS_T1_COEF       7'h73
`define OFS_T2_COEF       7'h74
// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_ZERO          8'h00
`define RST_GAIN_REF      6'h13
`define RST_GAIN_TH1      5'h0e
`define RST_GAIN_TH2      8'h5b
`define RST_GAIN_TH3      8'hdb
`define RST_HOP           8'h2e
`define RST_REF_SEL       8'h09
`define RST_BOOST         8'h84
`define RST_LOOP_BW       8'hd0
`define RST_T1_COEF       8'hf5
`define RST_T2_COEF       8'h20
// revision code, arbitrary value
`define REVISION_CODE     8'h15
// ----------------------------------------------------------------------
// field positions and codes
// ----------------------------------------------------------------------
`define BIT_SUPPLY_LOW    0
`define BIT_CHECK_PASS    1
`define BIT_PAYLOAD       2
`define BIT_TX_DONE       3
`define BIT_QUICK_HOP     7
`define BIT_EXT_REF       4
`define BIT_EVENT_CHOICE  0
`define BOOST_MAX         3'h7
`define LEVEL_MAX         4'hf
`define RX_TRANS_LEADIN   3'h6
`define RES_OFF           2'h0
`define RES_64US          2'h1
`define RES_4MS           2'h2
// ----------------------------------------------------------------------
// timing: tick of 64 us, longer resolutions are multiples of it
// ----------------------------------------------------------------------
`define CLK_MHZ           250
`define TICK_US           64
`define TICK_CYCLES       (`TICK_US * `CLK_MHZ)
`define TICKS_4MS         18'd64
`define TICKS_262MS       18'd4096
`endif

/* hw/radio_regs_pkg.sv */
package radio_regs_pkg;
  // sequencer states, gray along off-idle-receive
  typedef enum logic [1:0] {
    SEQ_OFF  = 2'b00,
    SEQ_IDLE = 2'b01,
    SEQ_RX   = 2'b11,
    SEQ_TX   = 2'b10
  } seq_state_t;
endpackage : radio_regs_pkg

/* hw/radio_ctrl_status_listen_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "radio_regs_defs.svh"
module radio_ctrl_status_listen_regs
  import radio_regs_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic [6:0] regAddr,          // register address
  input  wire logic [7:0] regWdata,         // write data
  input  wire logic       regWr,            // write strobe
  input  wire logic       regRd,            // read strobe
  output logic      [7:0] regRdata,         // read data, cycle after strobe
  input  wire logic       txActive,         // radio in transmit mode
  input  wire logic       rxActive,         // radio in receive mode
  input  wire logic       packetSentEvt,    // last bit sent
  input  wire logic       lastByteEvt,      // last payload byte received
  input  wire logic       checkMatchEvt,    // payload check matches
  input  wire logic       checkEnable,      // payload check enabled
  input  wire logic       checkFailKeep,    // keep payload on failed check
  input  wire logic       fifoEmpty,        // fifo empty level
  input  wire logic       supplyLowPin,     // comparator, asynchronous
  input  wire logic [3:0] outputLevelField, // transmit level setting
  input  wire logic       signalLevelEvent, // level event from receiver
  input  wire logic       leadInFound,      // lead-in detected
  input  wire logic [5:0] pinSourceA,       // per pin source for code 00
  input  wire logic [5:0] pinSourceB,       // per pin source for code 01
  input  wire logic [5:0] pinSourceC,       // per pin source for code 10
  input  wire logic [7:0] measuredTemp,     // temperature now
  input  wire logic       calDone,          // calibration finished pulse
  input  wire logic       synthForTx,       // synth for transmit requested
  input  wire logic       synthForRx,       // synth for receive requested
  input  wire logic       carrierLowWr,     // carrier low byte written
  output logic      [5:0] statusPins,       // status output pins
  output logic            carrierApply,     // apply new carrier frequency
  output logic            extRefSelect,     // external reference chosen
  output logic            maxBoostEnable,   // highest boost level active
  output logic      [1:0] loopBwCode,       // normal loop bandwidth
  output logic      [1:0] lowPnBwCode,      // low noise loop bandwidth
  output logic      [5:0] gainFloorLevel,   // gain floor
  output logic      [3:0] rateFraction,     // bit rate fraction
  output logic            seqRxReq,         // sequencer wants receive
  output logic            seqTxReq,         // sequencer wants transmit
  output logic            seqRunning        // sequencer on
);
  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic [7:0] mapLow_q;        // pin functions 0..3
  logic [7:0] mapHigh_q;       // pin functions 4..5 and event choice
  logic [5:0] gainRef_q;       // gain floor level
  logic [4:0] gainTh1_q;       // first step
  logic [7:0] gainTh2_q;       // steps two and three
  logic [7:0] gainTh3_q;       // steps four and five
  logic [7:0] hop_q;           // quick hop control
  logic [7:0] refSel_q;        // reference select
  logic [7:0] boost_q;         // boost setting
  logic [7:0] loopBw_q;        // loop bandwidth
  logic [7:0] lowPnBw_q;       // low noise loop bandwidth
  logic [7:0] calTemp_q;       // saved calibration temperature
  logic [3:0] rateFrac_q;      // rate fraction
  logic [7:0] seqCtrl_q;       // start, stop, idle, start, lp, idle, rx trans
  logic [3:0] seqTimers_q;     // t1 and t2 resolution
  logic [7:0] t1Coef_q;        // t1 coefficient
  logic [7:0] t2Coef_q;        // t2 coefficient
  logic       txDone_q;        // transmit done flag
  logic       payload_q;       // payload complete flag
  logic       checkPass_q;     // check pass flag
  logic       supplyLow_q;     // supply low flag
  logic       supplyMeta_q;    // synchroniser stage one
  logic       supplySync_q;    // synchroniser stage two
  logic [7:0] rdData_q;        // read data register
  seq_state_t seqState_q;      // sequencer state
  logic [17:0] tickCnt_q;      // 64 us tick divider
  logic [17:0] subCnt_q;       // ticks inside one unit
  logic [7:0] unitCnt_q;       // units elapsed
  logic       tick;            // 64 us enable pulse
  logic       wrEn;            // write of any register

  assign wrEn = regWr;

  // ----------------------------------------------------------------------
  // supply comparator crossing
  // ----------------------------------------------------------------------
  // comparator is asynchronous, two flops before any use
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      supplyMeta_q <= 1'b0;
      supplySync_q <= 1'b0;
    end
    else
    begin
      supplyMeta_q <= supplyLowPin;
      supplySync_q <= supplyMeta_q;
    end
  end

  // ----------------------------------------------------------------------
  // read-write configuration registers
  // ----------------------------------------------------------------------
  // reserved bits are kept as written, except in gain ref, first gain step, rate fraction and seq timers, which keep only their fields
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      mapLow_q    <= `RST_ZERO;
      mapHigh_q   <= `RST_ZERO;
      gainRef_q   <= `RST_GAIN_REF;
      gainTh1_q   <= `RST_GAIN_TH1;
      gainTh2_q   <= `RST_GAIN_TH2;
      gainTh3_q   <= `RST_GAIN_TH3;
      hop_q       <= `RST_HOP;
      refSel_q    <= `RST_REF_SEL;
      boost_q     <= `RST_BOOST;
      loopBw_q    <= `RST_LOOP_BW;
      lowPnBw_q   <= `RST_LOOP_BW;
      rateFrac_q  <= 4'h0;
      seqTimers_q <= 4'h0;
      t1Coef_q    <= `RST_T1_COEF;
      t2Coef_q    <= `RST_T2_COEF;
    end
    else if (wrEn)
    begin
      unique case (regAddr)
        `OFS_MAP_LOW:    mapLow_q    <= regWdata;
        `OFS_MAP_HIGH:   mapHigh_q   <= regWdata;
        `OFS_GAIN_REF:   gainRef_q   <= regWdata[5:0];
        `OFS_GAIN_TH1:   gainTh1_q   <= regWdata[4:0];
        `OFS_GAIN_TH2:   gainTh2_q   <= regWdata;
        `OFS_GAIN_TH3:   gainTh3_q   <= regWdata;
        `OFS_HOP:        hop_q       <= regWdata;
        `OFS_REF_SEL:    refSel_q    <= regWdata;
        `OFS_BOOST:      boost_q     <= regWdata;
        `OFS_LOOP_BW:    loopBw_q    <= regWdata;
        `OFS_LOW_PN_BW:  lowPnBw_q   <= regWdata;
        `OFS_RATE_FRAC:  rateFrac_q  <= regWdata[3:0];
        `OFS_SEQ_TIMERS: seqTimers_q <= regWdata[3:0];
        `OFS_T1_COEF:    t1Coef_q    <= regWdata;
        `OFS_T2_COEF:    t2Coef_q    <= regWdata;
        default:         ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // saved calibration temperature
  // ----------------------------------------------------------------------
  // calibration capture wins over a software write in the same cycle
  always_ff @(posedge clock)
  begin
    if (srst)
      calTemp_q <= `RST_ZERO;
    else if (calDone)
      calTemp_q <= measuredTemp;
    else if (wrEn && regAddr == `OFS_CAL_TEMP)
      calTemp_q <= regWdata;
  end

  // ----------------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------------
  // transmit done follows transmit mode, read only
  always_ff @(posedge clock)
  begin
    if (srst || !txActive)
      txDone_q <= 1'b0;
    else if (packetSentEvt)
      txDone_q <= 1'b1;
  end

  // payload and check flags clear on empty fifo; a new event wins
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      payload_q   <= 1'b0;
      checkPass_q <= 1'b0;
    end
    else
    begin
      if (rxActive && lastByteEvt && (!checkEnable || checkFailKeep || checkMatchEvt))
        payload_q <= 1'b1;
      else if (fifoEmpty)
        payload_q <= 1'b0;
      if (rxActive && checkMatchEvt)
        checkPass_q <= 1'b1;
      else if (fifoEmpty)
        checkPass_q <= 1'b0;
    end
  end

  // supply low is sticky; set wins over a write-one clear
  always_ff @(posedge clock)
  begin
    if (srst)
      supplyLow_q <= 1'b0;
    else if (supplySync_q)
      supplyLow_q <= 1'b1;
    else if (wrEn && regAddr == `OFS_FLAGS2 && regWdata[`BIT_SUPPLY_LOW])
      supplyLow_q <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // sequencer control register
  // ----------------------------------------------------------------------
  // bit 7 start and bit 6 stop are pulses and read back as zero
  always_ff @(posedge clock)
  begin
    if (srst)
      seqCtrl_q <= `RST_ZERO;
    else if (wrEn && regAddr == `OFS_SEQ_CTRL)
      seqCtrl_q <= {2'b00, regWdata[5:0]};
  end

  // ----------------------------------------------------------------------
  // 64 us tick divider
  // ----------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst || tickCnt_q == 18'(`TICK_CYCLES - 1))
      tickCnt_q <= 18'd0;
    else
      tickCnt_q <= tickCnt_q + 18'd1;
  end
  assign tick = (tickCnt_q == 18'(`TICK_CYCLES - 1));

  // ----------------------------------------------------------------------
  // interval timer: resolution unit times coefficient
  // ----------------------------------------------------------------------
  logic [1:0]  curRes;    // resolution of running interval
  logic [7:0]  curCoef;   // coefficient of running interval
  logic [17:0] unitTicks; // ticks per unit
  logic        unitDone;  // one unit elapsed
  logic        intervalEnd; // running interval complete
  assign curRes    = (seqState_q == SEQ_IDLE) ? seqTimers_q[3:2] : seqTimers_q[1:0];
  assign curCoef   = (seqState_q == SEQ_IDLE) ? t1Coef_q : t2Coef_q;
  assign unitTicks = (curRes == `RES_64US) ? 18'd1 :
                     (curRes == `RES_4MS)  ? `TICKS_4MS : `TICKS_262MS;
  assign unitDone  = tick && (subCnt_q == unitTicks - 18'd1);
  assign intervalEnd = (curRes != `RES_OFF) && unitDone &&
                       (unitCnt_q + 8'd1 >= curCoef);

  always_ff @(posedge clock)
  begin
    if (srst || seqState_q == SEQ_OFF || intervalEnd)
    begin
      subCnt_q  <= 18'd0;
      unitCnt_q <= 8'd0;
    end
    else if (unitDone)
    begin
      subCnt_q  <= 18'd0;
      unitCnt_q <= unitCnt_q + 8'd1;
    end
    else if (tick)
      subCnt_q <= subCnt_q + 18'd1;
  end

  // ----------------------------------------------------------------------
  // listen sequencer
  // ----------------------------------------------------------------------
  // only the wake-on-lead-in and the wake-into-transmit paths are modelled; receive ends on t2
  always_ff @(posedge clock)
  begin
    if (srst || (wrEn && regAddr == `OFS_SEQ_CTRL && regWdata[6]))
      seqState_q <= SEQ_OFF;
    else
    begin
      unique case (seqState_q)
        SEQ_OFF:
          if (wrEn && regAddr == `OFS_SEQ_CTRL && regWdata[7])
            seqState_q <= (regWdata[2] && regWdata[4:3] == 2'b00) ? SEQ_IDLE : SEQ_OFF;
        SEQ_IDLE:
          if (intervalEnd)
            seqState_q <= seqCtrl_q[1] ? SEQ_RX : SEQ_TX;
        SEQ_RX:
          if (leadInFound)
            seqState_q <= SEQ_OFF;
          else if (intervalEnd)
            seqState_q <= SEQ_IDLE;
        SEQ_TX:
          if (packetSentEvt)
            seqState_q <= SEQ_IDLE;
      endcase
    end
  end

  assign seqRunning = (seqState_q != SEQ_OFF);
  assign seqRxReq   = (seqState_q == SEQ_RX);
  assign seqTxReq   = (seqState_q == SEQ_TX);

  // ----------------------------------------------------------------------
  // status pin mapping
  // ----------------------------------------------------------------------
  logic [11:0] pinCodes; // two bits per pin, pin 0 in top of low map
  logic        pinEvent; // event for code 11
  assign pinCodes = {mapLow_q, mapHigh_q[7:4]};
  assign pinEvent = mapHigh_q[`BIT_EVENT_CHOICE] ? leadInFound : signalLevelEvent;

  genvar gp;
  generate
    for (gp = 0; gp < 6; gp++)
    begin : g_pin
      logic [1:0] code;
      assign code = pinCodes[11 - 2*gp -: 2];
      always_ff @(posedge clock)
      begin
        if (srst)
          statusPins[gp] <= 1'b0;
        else
        begin
          unique case (code)
            2'b00: statusPins[gp] <= pinSourceA[gp];
            2'b01: statusPins[gp] <= pinSourceB[gp];
            2'b10: statusPins[gp] <= pinSourceC[gp];
            2'b11: statusPins[gp] <= pinEvent;
          endcase
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // control outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
      carrierApply <= 1'b0;
    else if (hop_q[`BIT_QUICK_HOP])
      carrierApply <= carrierLowWr;
    else
      carrierApply <= synthForTx || synthForRx;
  end

  assign extRefSelect   = refSel_q[`BIT_EXT_REF];
  assign maxBoostEnable = (boost_q[2:0] == `BOOST_MAX) && (outputLevelField == `LEVEL_MAX);
  assign loopBwCode     = loopBw_q[7:6];
  assign lowPnBwCode    = lowPnBw_q[7:6];
  assign gainFloorLevel = gainRef_q;
  assign rateFraction   = rateFrac_q;

  // ----------------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
      rdData_q <= 8'h00;
    else if (regRd)
    begin
      unique case (regAddr)
        `OFS_FLAGS2:     rdData_q <= {4'h0, txDone_q, payload_q, checkPass_q, supplyLow_q};
        `OFS_MAP_LOW:    rdData_q <= mapLow_q;
        `OFS_MAP_HIGH:   rdData_q <= mapHigh_q;
        `OFS_REVISION:   rdData_q <= `REVISION_CODE;
        `OFS_GAIN_REF:   rdData_q <= {2'b00, gainRef_q};
        `OFS_GAIN_TH1:   rdData_q <= {3'b000, gainTh1_q};
        `OFS_GAIN_TH2:   rdData_q <= gainTh2_q;
        `OFS_GAIN_TH3:   rdData_q <= gainTh3_q;
        `OFS_HOP:        rdData_q <= hop_q;
        `OFS_REF_SEL:    rdData_q <= refSel_q;
        `OFS_BOOST:      rdData_q <= boost_q;
        `OFS_LOOP_BW:    rdData_q <= loopBw_q;
        `OFS_LOW_PN_BW:  rdData_q <= lowPnBw_q;
        `OFS_CAL_TEMP:   rdData_q <= calTemp_q;
        `OFS_RATE_FRAC:  rdData_q <= {4'h0, rateFrac_q};
        `OFS_SEQ_CTRL:   rdData_q <= seqCtrl_q;
        `OFS_SEQ_TIMERS: rdData_q <= {4'h0, seqTimers_q};
        `OFS_T1_COEF:    rdData_q <= t1Coef_q;
        `OFS_T2_COEF:    rdData_q <= t2Coef_q;
        default:         rdData_q <= 8'h00;            // unmapped reads zero
      endcase
    end
  end
  assign regRdata = rdData_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  tx_done_drop_a: assert property (@(posedge clock) disable iff (srst)
    !txActive |=> !txDone_q) else $error("transmit done kept outside transmit");
  supply_sticky_a: assert property (@(posedge clock) disable iff (srst)
    supplyLow_q && !(wrEn && regAddr == `OFS_FLAGS2 && regWdata[0]) |=> supplyLow_q)
    else $error("supply low cleared without write");
  zero_write_keep_a: assert property (@(posedge clock) disable iff (srst)
    supplyLow_q && wrEn && regAddr == `OFS_FLAGS2 && !regWdata[0] |=> supplyLow_q)
    else $error("zero write cleared flag");
  check_clear_a: assert property (@(posedge clock) disable iff (srst)
    fifoEmpty && !(rxActive && checkMatchEvt) |=> !checkPass_q)
    else $error("check pass not cleared on empty");
  payload_set_a: assert property (@(posedge clock) disable iff (srst)
    rxActive && lastByteEvt && !checkEnable |=> payload_q)
    else $error("payload complete missing");
  revision_read_a: assert property (@(posedge clock) disable iff (srst)
    regRd && regAddr == `OFS_REVISION |=> regRdata == `REVISION_CODE)
    else $error("revision read wrong");
  lead_in_off_a: assert property (@(posedge clock) disable iff (srst)
    seqState_q == SEQ_RX && leadInFound |=> seqState_q == SEQ_OFF)
    else $error("sequencer did not stop on lead-in");
  quick_hop_a: assert property (@(posedge clock) disable iff (srst)
    hop_q[7] && carrierLowWr |=> carrierApply)
    else $error("quick hop not applied");
  cv_listen_c: cover property (@(posedge clock) seqState_q == SEQ_IDLE ##1 seqState_q == SEQ_RX);
  cv_leadin_c: cover property (@(posedge clock) seqState_q == SEQ_RX ##1 seqState_q == SEQ_OFF);
  cv_supply_c: cover property (@(posedge clock) $fell(supplyLow_q));
endmodule : radio_ctrl_status_listen_regs
`default_nettype wire

/* sim/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// host side of the register port; drives only after rising edges
module host_model (
  input  wire logic       clock,
  output logic      [6:0] regAddr,
  output logic      [7:0] regWdata,
  output logic            regWr,
  output logic            regRd,
  input  wire logic [7:0] regRdata
);
  initial {regAddr, regWdata, regWr, regRd} = '0;
  // quiet spell after reset release before the first access
  task automatic settle;
    repeat (8) @(posedge clock);
  endtask : settle
  // one-cycle write; released lines show the inverse, never the old value
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clock);
    regWr    <= 1'b0;
    regAddr  <= ~a;
    regWdata <= ~d;
  endtask : wr
  // one-cycle read; data taken mid-way through the following cycle
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clock);
    regRd   <= 1'b0;
    regAddr <= ~a;
    @(negedge clock);
    d = regRdata;
    @(posedge clock);
  endtask : rd
endmodule : host_model
`default_nettype wire

/* sim/radio_ctrl_status_listen_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "radio_regs_defs.svh"
module radio_ctrl_status_listen_regs_tb;
  logic clock = '0, srst = '1, txActive = '0, rxActive = '0, packetSentEvt = '0;
  logic lastByteEvt = '0, checkMatchEvt = '0, checkEnable = '1, checkFailKeep = '0;
  logic fifoEmpty = '0, supplyLowPin = '0, signalLevelEvent = '0, leadInFound = '0;
  logic calDone = '0, synthForTx = '0, synthForRx = '0, carrierLowWr = '0;
  logic regWr, regRd, carrierApply, extRefSelect, maxBoostEnable;
  logic seqRxReq, seqTxReq, seqRunning;
  logic [3:0] outputLevelField = 4'hf, rateFraction;
  logic [5:0] pinSourceA = '0, pinSourceB = '0, pinSourceC = '0, statusPins, gainFloorLevel;
  logic [7:0] measuredTemp = '0, regWdata, regRdata, v;
  logic [6:0] regAddr, a;
  logic [1:0] loopBwCode, lowPnBwCode;
  logic [31:0] seed = 32'hc800;
  int errorCnt = 0, checks = 0, n;
  // mapped registers and their reset values
  logic [6:0] adr [13] = '{7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46,
                           7'h4b, 7'h58, 7'h5a, 7'h5c, 7'h5e, 7'h70};
  logic [7:0] rst [13] = '{8'h00, 8'h00, `REVISION_CODE, 8'h13, 8'h0e, 8'h5b, 8'hdb,
                           8'h2e, 8'h09, 8'h84, 8'hd0, 8'hd0, 8'h00};
  host_model host (.clock, .regAddr, .regWdata, .regWr, .regRd, .regRdata);
  radio_ctrl_status_listen_regs dut (.clock, .srst, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .txActive, .rxActive, .packetSentEvt, .lastByteEvt, .checkMatchEvt,
    .checkEnable, .checkFailKeep, .fifoEmpty, .supplyLowPin, .outputLevelField,
    .signalLevelEvent, .leadInFound, .pinSourceA, .pinSourceB, .pinSourceC, .measuredTemp,
    .calDone, .synthForTx, .synthForRx, .carrierLowWr, .statusPins, .carrierApply,
    .extRefSelect, .maxBoostEnable, .loopBwCode, .lowPnBwCode, .gainFloorLevel,
    .rateFraction, .seqRxReq, .seqTxReq, .seqRunning);
  initial forever #2 clock = ~clock;
  // xorshift source, fixed start so runs repeat
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  // readable bits after a write; unused bits read zero, revision ignores writes
  function automatic logic [7:0] expect_rd(input logic [6:0] r, input logic [7:0] d);
    case (r)
      7'h42:   return `REVISION_CODE;
      7'h43:   return d & 8'h3f;
      7'h44:   return d & 8'h1f;
      7'h70:   return d & 8'h0f;
      default: return d;
    endcase
  endfunction : expect_rd
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e)
    begin
      errorCnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic rc(input logic [6:0] r, input logic [7:0] e);
    host.rd(r, v);
    chk(v, e);
  endtask : rc
  task automatic complete_run;
    if (errorCnt == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  // watchdog at 80000 cycles, only a little above the four 16000-cycle ticks the listen checks can take
  initial
  begin
    repeat (80000) @(posedge clock);
    errorCnt++;
    complete_run();
  end
  initial
  begin
    repeat (20) @(posedge clock);
    srst <= '0;
    host.settle();
    for (int i = 0; i < 13; i++)
      rc(adr[i], rst[i]);
    rc(7'h7f, 8'h00);
    // random writes over the 13 registers of the table, twice round
    for (int i = 0; i < 26; i++)
    begin
      seed = xs(seed);
      a = adr[i % 13];
      {signalLevelEvent, pinSourceB, pinSourceC} <= seed[30:18];
      host.wr(a, seed[7:0]);
      rc(a, expect_rd(a, seed[7:0]));
    end
    // decoded outputs follow their fields
    host.rd(7'h5c, v);
    chk(loopBwCode, v[7:6]);
    host.rd(7'h5e, v);
    chk(lowPnBwCode, v[7:6]);
    host.rd(7'h58, v);
    chk(extRefSelect, v[4]);
    host.rd(7'h43, v);
    chk(gainFloorLevel, v);
    host.rd(7'h70, v);
    chk(rateFraction, v);
    // top boost only with full output level
    host.wr(7'h5a, 8'h87);
    @(negedge clock);
    chk(maxBoostEnable, 8'h01);
    @(posedge clock);
    outputLevelField <= 4'he;
    @(negedge clock);
    chk(maxBoostEnable, 8'h00);
    // calibration captures the temperature
    @(posedge clock);
    measuredTemp <= seed[23:16];
    calDone <= '1;
    @(posedge clock);
    calDone <= '0;
    rc(7'h6c, seed[23:16]);
    // sticky supply flag, cleared only by a written one
    supplyLowPin <= '1;
    repeat (5) @(posedge clock);
    supplyLowPin <= '0;
    rc(7'h3f, 8'h01);
    host.wr(7'h3f, 8'h00);
    rc(7'h3f, 8'h01);
    host.wr(7'h3f, 8'h01);
    rc(7'h3f, 8'h00);
    // transmit done stands until transmit is left
    txActive <= '1;
    packetSentEvt <= '1;
    @(posedge clock);
    packetSentEvt <= '0;
    rc(7'h3f, 8'h08);
    txActive <= '0;
    rc(7'h3f, 8'h00);
    // payload and check pass, both dropped by an empty fifo
    rxActive <= '1;
    {checkMatchEvt, lastByteEvt} <= '1;
    @(posedge clock);
    {checkMatchEvt, lastByteEvt} <= '0;
    rc(7'h3f, 8'h06);
    fifoEmpty <= '1;
    rc(7'h3f, 8'h00);
    // with the check off the last byte alone completes the payload
    {checkEnable, fifoEmpty, lastByteEvt} <= 3'b001;
    @(posedge clock);
    lastByteEvt <= '0;
    rc(7'h3f, 8'h04);
    // pins 0..3 take codes 00..11, pin four the lead-in event
    pinSourceA <= seed[5:0];
    host.wr(7'h40, 8'h1b);
    host.wr(7'h41, 8'hc1);
    leadInFound <= '1;
    repeat (3) @(posedge clock);
    chk(statusPins, {seed[5], 2'b11, pinSourceC[2], pinSourceB[1], seed[0]});
    // choice bit cleared hands the event pins the level event instead
    signalLevelEvent <= '0;
    host.wr(7'h41, 8'hc0);
    repeat (3) @(posedge clock);
    chk(statusPins[4], 8'h00);
    // low carrier byte applies only with quick hop on, synth request only with it off
    for (int k = 0; k < 2; k++)
    begin
      host.wr(7'h4b, {k[0], 7'h2e});
      carrierLowWr <= '1;
      @(posedge clock);
      {carrierLowWr, synthForRx} <= 2'b01;
      @(negedge clock);
      chk(carrierApply, 8'(k));
      @(posedge clock);
      synthForRx <= '0;
      @(negedge clock);
      chk(carrierApply, 8'(1 - k));
    end
    // listen: one tick per interval, receive for t2, idle for t1, off on lead-in
    leadInFound <= '0;
    host.wr(7'h72, 8'h05);
    host.wr(7'h73, 8'h01);
    host.wr(7'h74, 8'h01);
    host.wr(7'h71, 8'ha6);
    for (n = 0; n < 17000 && !seqRxReq; n++) @(negedge clock);
    chk({seqRxReq, seqTxReq}, 8'h02);
    for (n = 0; n < 17000 && seqRxReq; n++) @(negedge clock);
    chk(8'(n == `TICK_CYCLES), 8'h01);
    chk(seqRunning, 8'h01);
    for (n = 0; n < 17000 && !seqRxReq; n++) @(negedge clock);
    chk(8'(n == `TICK_CYCLES), 8'h01);
    @(posedge clock);
    leadInFound <= '1;
    @(posedge clock);
    leadInFound <= '0;
    @(negedge clock);
    chk({seqRunning, seqRxReq}, 8'h00);
    // idle transition cleared wakes into transmit instead
    host.wr(7'h71, 8'ha4);
    for (n = 0; n < 17000 && !seqTxReq; n++) @(negedge clock);
    chk({seqRxReq, seqTxReq}, 8'h01);
    complete_run();
  end
endmodule : radio_ctrl_status_listen_regs_tb
`default_nettype wire
